// ---- rtl/vss_params.svh ----
// register offsets, field positions, reset values and timing for the monitor
`ifndef VSS_PARAMS_SVH
`define VSS_PARAMS_SVH

`define VSS_OFS_CTRL      8'h00
`define VSS_OFS_SURGE_LIM 8'h01
`define VSS_OFS_DIP_LIM   8'h02
`define VSS_OFS_DELAY     8'h03
`define VSS_OFS_BLOCK_LIM 8'h04
`define VSS_OFS_STATUS    8'h05
`define VSS_OFS_MASK      8'h06
`define VSS_OFS_LIVE      8'h07
`define VSS_OFS_DIP_CNT   8'h08
`define VSS_OFS_SURGE_CNT 8'h09
`define VSS_OFS_DIP_TOT   8'h0a
`define VSS_OFS_SURGE_TOT 8'h0b
`define VSS_OFS_LOG_SEL   8'h0c
`define VSS_OFS_LOG_STAMP 8'h10
`define VSS_OFS_LOG_TYPE  8'h11
`define VSS_OFS_LOG_DUR   8'h12
`define VSS_OFS_LOG_LVL   8'h13

`define VSS_BIT_DIP_START   0
`define VSS_BIT_DIP_END     1
`define VSS_BIT_SURGE_START 2
`define VSS_BIT_SURGE_END   3

`define VSS_RST_CTRL      4'hf
`define VSS_RST_SURGE_LIM 8'h6e
`define VSS_RST_DIP_LIM   8'h5a
`define VSS_RST_DELAY     6'h03
`define VSS_RST_BLOCK_LIM 8'h00

`define VSS_SURGE_MIN 8'h14
`define VSS_SURGE_MAX 8'h96
`define VSS_DIP_MIN   8'h0a
`define VSS_DIP_MAX   8'h78
`define VSS_DELAY_MIN 6'h02
`define VSS_DELAY_MAX 6'h32
`define VSS_BLOCK_MAX 8'h32

`define VSS_STEP_US 20000
`define VSS_CLK_MHZ 100

`endif

// ---- rtl/vss_pkg.sv ----
// types shared by the sag and swell monitor modules
package vss_pkg;

  typedef logic [2:0][7:0] volt_t;

  typedef struct packed {
    logic [31:0] stamp;
    logic [2:0] inputs;
    logic [15:0] duration;
    logic [2:0][7:0] lowest;
    logic [2:0][7:0] mean;
    logic [2:0][7:0] highest;
  } rec_s;

  typedef enum logic [1:0] {
    TRK_IDLE,
    TRK_QUAL,
    TRK_ACTIVE
  } trk_state_e;

endpackage : vss_pkg

// ---- rtl/vss_tracker.sv ----
// one condition tracker: detection delay, duration and per-input statistics
`timescale 1ns/1ns
module vss_tracker import vss_pkg::*; (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_reset,
  // timing and samples
  input wire logic i_tick,
  input wire logic i_sample_valid,
  input wire volt_t i_volt,
  input wire logic [31:0] i_stamp,
  // condition
  input wire logic [2:0] i_viol,
  input wire logic i_block,
  input wire logic [5:0] i_delay,
  // results
  output logic o_pending,
  output logic o_active,
  output logic o_start,
  output logic o_end,
  output rec_s o_rec
);

  trk_state_e state_r, state_nxt;
  logic [5:0] wait_r;
  logic [15:0] dur_r;
  logic [15:0] nsamp_r;
  logic [2:0][23:0] sum_r;
  logic [2:0][7:0] lo_r;
  logic [2:0][7:0] hi_r;
  logic [2:0][7:0] mean;
  logic [2:0] hit_r;
  logic [31:0] stamp_r;
  logic start_r;
  logic end_r;
  rec_s rec_r;

  wire viol = |i_viol && !i_block;
  wire qualified = i_tick && ((wait_r + 6'h01) >= i_delay);
  wire go_active = state_r == TRK_QUAL && viol && qualified;
  wire finish = state_r == TRK_ACTIVE && !viol;
  wire opening = state_r == TRK_IDLE && viol;
  wire take = i_sample_valid && state_r != TRK_IDLE && nsamp_r != 16'hffff;

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      TRK_IDLE: if (viol) state_nxt = TRK_QUAL;
      TRK_QUAL: begin
        if (!viol) state_nxt = TRK_IDLE;
        else if (qualified) state_nxt = TRK_ACTIVE;
      end
      TRK_ACTIVE: if (!viol) state_nxt = TRK_IDLE;
      default: state_nxt = TRK_IDLE;
    endcase
  end

  // an event with no sample yet reports the present level as its mean
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_in
      assign mean[gi] = (nsamp_r == 16'h0000) ? i_volt[gi] :
        8'(sum_r[gi] / 24'(nsamp_r));
      always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
          sum_r[gi] <= 24'h000000;
          lo_r[gi] <= 8'hff;
          hi_r[gi] <= 8'h00;
        end else if (opening) begin
          sum_r[gi] <= 24'h000000;
          lo_r[gi] <= 8'hff;
          hi_r[gi] <= 8'h00;
        end else if (take) begin
          sum_r[gi] <= sum_r[gi] + 24'(i_volt[gi]);
          if (i_volt[gi] < lo_r[gi]) lo_r[gi] <= i_volt[gi];
          if (i_volt[gi] > hi_r[gi]) hi_r[gi] <= i_volt[gi];
        end
      end
    end
  endgenerate

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      state_r <= TRK_IDLE;
      wait_r <= 6'h00;
      dur_r <= 16'h0000;
      nsamp_r <= 16'h0000;
      hit_r <= 3'h0;
      stamp_r <= 32'h00000000;
    end else begin
      state_r <= state_nxt;
      if (opening) begin
        wait_r <= 6'h00;
        dur_r <= 16'h0000;
        nsamp_r <= 16'h0000;
        hit_r <= i_viol;
        stamp_r <= i_stamp;
      end else if (state_r != TRK_IDLE) begin
        hit_r <= hit_r | i_viol;
        if (take) nsamp_r <= nsamp_r + 16'h0001;
        if (i_tick && state_r == TRK_QUAL) wait_r <= wait_r + 6'h01;
        if (i_tick && dur_r != 16'hffff) dur_r <= dur_r + 16'h0001;
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      start_r <= 1'b0;
      end_r <= 1'b0;
      rec_r <= '0;
    end else begin
      start_r <= go_active;
      end_r <= finish;
      if (finish) begin
        rec_r.stamp <= stamp_r;
        rec_r.inputs <= hit_r;
        rec_r.duration <= dur_r;
        rec_r.lowest <= lo_r;
        rec_r.mean <= mean;
        rec_r.highest <= hi_r;
      end
    end
  end

  assign o_pending = state_r == TRK_QUAL;
  assign o_active = state_r == TRK_ACTIVE;
  assign o_start = start_r;
  assign o_end = end_r;
  assign o_rec = rec_r;

endmodule : vss_tracker

// ---- rtl/voltage_sag_swell_monitor.sv ----
// three-input sag and swell monitor with event logs, counters and registers
`timescale 1ns/1ns
`include "vss_params.svh"
module voltage_sag_swell_monitor import vss_pkg::*; #(
  parameter int STEP_CYCLES = `VSS_STEP_US * `VSS_CLK_MHZ,
  parameter int LOG_DEPTH = 4
)(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_reset,
  // measurement front end
  input wire logic i_sample_valid,
  input wire volt_t i_volt,
  input wire logic [31:0] i_rtc,
  // register port
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  // status
  output logic o_dip_active,
  output logic o_surge_active,
  output logic o_irq
);

  localparam int PTR_W = $clog2(LOG_DEPTH);

  generate
    // the select register carries only a two-bit record index
    if (STEP_CYCLES < 1 || LOG_DEPTH < 2 || LOG_DEPTH > 4 ||
      (LOG_DEPTH & (LOG_DEPTH - 1)) != 0)
    begin : g_bad
      $error("step count must be positive, log depth 2 or 4");
    end
  endgenerate

  // reset settings must sit inside the ranges that the write path accepts
  generate
    if (`VSS_RST_SURGE_LIM < `VSS_SURGE_MIN ||
      `VSS_RST_SURGE_LIM > `VSS_SURGE_MAX ||
      `VSS_RST_DIP_LIM < `VSS_DIP_MIN || `VSS_RST_DIP_LIM > `VSS_DIP_MAX ||
      `VSS_RST_DELAY < `VSS_DELAY_MIN || `VSS_RST_DELAY > `VSS_DELAY_MAX)
    begin : g_bad_rst
      $error("reset settings lie outside the accepted ranges");
    end
  endgenerate

  logic [3:0] ctrl_r;
  logic [7:0] surge_lim_r;
  logic [7:0] dip_lim_r;
  logic [5:0] delay_r;
  logic [7:0] block_lim_r;
  logic [3:0] status_r;
  logic [3:0] mask_r;
  logic [2:0] sel_r;
  logic [15:0] dip_cnt_r;
  logic [15:0] surge_cnt_r;
  logic [31:0] dip_tot_r;
  logic [31:0] surge_tot_r;
  logic [31:0] tick_cnt_r;
  logic [31:0] rdata_r;
  logic [PTR_W-1:0] dip_ptr_r;
  logic [PTR_W-1:0] surge_ptr_r;
  rec_s dip_log_r [LOG_DEPTH];
  rec_s surge_log_r [LOG_DEPTH];

  // level comparison per input
  logic [2:0] dip_viol;
  logic [2:0] surge_viol;
  logic [2:0] below_block;
  logic [2:0] mid_band;
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_cmp
      assign dip_viol[gi] = i_volt[gi] < dip_lim_r;
      assign surge_viol[gi] = i_volt[gi] > surge_lim_r;
      assign below_block[gi] = i_volt[gi] < block_lim_r;
      assign mid_band[gi] = i_volt[gi] >= block_lim_r && dip_viol[gi];
    end
  endgenerate

  // a dead supply is not a sag, unless another line still sits mid-band
  wire blocked = |below_block && !(|mid_band);

  // one tick per delay step; the first step of a wait may run short
  wire tick = tick_cnt_r == 32'(STEP_CYCLES - 1);

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) tick_cnt_r <= 32'h00000000;
    else tick_cnt_r <= tick ? 32'h00000000 : tick_cnt_r + 32'h00000001;
  end

  logic dip_pending, dip_start, dip_end;
  logic surge_pending, surge_start, surge_end;
  rec_s dip_rec, surge_rec;

  vss_tracker u_dip (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_tick(tick),
    .i_sample_valid(i_sample_valid),
    .i_volt(i_volt),
    .i_stamp(i_rtc),
    .i_viol(dip_viol),
    .i_block(blocked),
    .i_delay(delay_r),
    .o_pending(dip_pending),
    .o_active(o_dip_active),
    .o_start(dip_start),
    .o_end(dip_end),
    .o_rec(dip_rec)
  );

  vss_tracker u_surge (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_tick(tick),
    .i_sample_valid(i_sample_valid),
    .i_volt(i_volt),
    .i_stamp(i_rtc),
    .i_viol(surge_viol),
    .i_block(1'b0),
    .i_delay(delay_r),
    .o_pending(surge_pending),
    .o_active(o_surge_active),
    .o_start(surge_start),
    .o_end(surge_end),
    .o_rec(surge_rec)
  );

  // register write decode
  wire wr_ctrl = i_wr && i_addr == `VSS_OFS_CTRL;
  wire wr_surge = i_wr && i_addr == `VSS_OFS_SURGE_LIM;
  wire wr_dip = i_wr && i_addr == `VSS_OFS_DIP_LIM;
  wire wr_delay = i_wr && i_addr == `VSS_OFS_DELAY;
  wire wr_block = i_wr && i_addr == `VSS_OFS_BLOCK_LIM;
  wire wr_status = i_wr && i_addr == `VSS_OFS_STATUS;
  wire wr_mask = i_wr && i_addr == `VSS_OFS_MASK;
  wire wr_sel = i_wr && i_addr == `VSS_OFS_LOG_SEL;
  wire [7:0] wbyte = i_wdata[7:0];
  wire [5:0] wdelay = i_wdata[5:0];
  wire wide_zero = i_wdata[31:8] == 24'h000000;

  // out-of-range settings are ignored and the old value kept
  wire surge_ok = wide_zero && wbyte >= `VSS_SURGE_MIN &&
    wbyte <= `VSS_SURGE_MAX;
  wire dip_ok = wide_zero && wbyte >= `VSS_DIP_MIN && wbyte <= `VSS_DIP_MAX;
  wire delay_ok = i_wdata[31:6] == 26'h0000000 &&
    wdelay >= `VSS_DELAY_MIN && wdelay <= `VSS_DELAY_MAX;
  wire block_ok = wide_zero && wbyte <= `VSS_BLOCK_MAX;

  logic [3:0] evt_set;
  assign evt_set[`VSS_BIT_DIP_START] = dip_start;
  assign evt_set[`VSS_BIT_DIP_END] = dip_end;
  assign evt_set[`VSS_BIT_SURGE_START] = surge_start;
  assign evt_set[`VSS_BIT_SURGE_END] = surge_end;

  // a new event wins over a clear in the same cycle
  wire [3:0] clr = wr_status ? i_wdata[3:0] : 4'h0;
  logic [3:0] status_nxt;
  genvar bi;
  generate
    for (bi = 0; bi < 4; bi++) begin : g_status
      assign status_nxt[bi] = (status_r[bi] && !clr[bi]) ||
        (evt_set[bi] && ctrl_r[bi]);
    end
  endgenerate

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      surge_lim_r <= `VSS_RST_SURGE_LIM;
      dip_lim_r <= `VSS_RST_DIP_LIM;
      delay_r <= `VSS_RST_DELAY;
      block_lim_r <= `VSS_RST_BLOCK_LIM;
    end else begin
      if (wr_surge && surge_ok) surge_lim_r <= wbyte;
      if (wr_dip && dip_ok) dip_lim_r <= wbyte;
      if (wr_delay && delay_ok) delay_r <= wdelay;
      if (wr_block && block_ok) block_lim_r <= wbyte;
    end
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      ctrl_r <= `VSS_RST_CTRL;
      mask_r <= 4'h0;
      sel_r <= 3'h0;
      status_r <= 4'h0;
    end else begin
      if (wr_ctrl) ctrl_r <= i_wdata[3:0];
      if (wr_mask) mask_r <= i_wdata[3:0];
      if (wr_sel) sel_r <= i_wdata[2:0];
      status_r <= status_nxt;
    end
  end

  // durations in delay steps; counts saturate, totals wrap after long use
  wire dip_cnt_full = dip_cnt_r == 16'hffff;
  wire surge_cnt_full = surge_cnt_r == 16'hffff;

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      dip_cnt_r <= 16'h0000;
      dip_tot_r <= 32'h00000000;
    end else if (dip_end) begin
      if (!dip_cnt_full) dip_cnt_r <= dip_cnt_r + 16'h0001;
      dip_tot_r <= dip_tot_r + 32'(dip_rec.duration);
    end
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      surge_cnt_r <= 16'h0000;
      surge_tot_r <= 32'h00000000;
    end else if (surge_end) begin
      if (!surge_cnt_full) surge_cnt_r <= surge_cnt_r + 16'h0001;
      surge_tot_r <= surge_tot_r + 32'(surge_rec.duration);
    end
  end

  // records are written when the event closes; the pointer marks the oldest
  logic [LOG_DEPTH-1:0] dip_slot_we;
  logic [LOG_DEPTH-1:0] surge_slot_we;
  genvar ri;
  generate
    for (ri = 0; ri < LOG_DEPTH; ri++) begin : g_log
      assign dip_slot_we[ri] = dip_end && dip_ptr_r == PTR_W'(ri);
      assign surge_slot_we[ri] = surge_end && surge_ptr_r == PTR_W'(ri);
      always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
          dip_log_r[ri] <= '0;
          surge_log_r[ri] <= '0;
        end else begin
          if (dip_slot_we[ri]) dip_log_r[ri] <= dip_rec;
          if (surge_slot_we[ri]) surge_log_r[ri] <= surge_rec;
        end
      end
    end
  endgenerate

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      dip_ptr_r <= '0;
      surge_ptr_r <= '0;
    end else begin
      if (dip_end) dip_ptr_r <= dip_ptr_r + PTR_W'(1);
      if (surge_end) surge_ptr_r <= surge_ptr_r + PTR_W'(1);
    end
  end

  // read selection
  wire [PTR_W-1:0] sel_idx = sel_r[PTR_W:1];
  wire rec_s sel_rec = sel_r[0] ? surge_log_r[sel_idx] : dip_log_r[sel_idx];
  wire [7:0] lvl_idx = i_addr - `VSS_OFS_LOG_LVL;
  wire [1:0] lvl_in = 2'(lvl_idx / 8'h03);
  wire [1:0] lvl_kind = 2'(lvl_idx % 8'h03);
  wire lvl_hit = i_addr >= `VSS_OFS_LOG_LVL && lvl_idx < 8'h09;
  wire [7:0] lvl_val = (lvl_kind == 2'h0) ? sel_rec.lowest[lvl_in] :
    (lvl_kind == 2'h1) ? sel_rec.mean[lvl_in] : sel_rec.highest[lvl_in];
  wire [4:0] live = {surge_pending, dip_pending, blocked,
    o_surge_active, o_dip_active};

  logic [31:0] rdata_nxt;
  always_comb begin
    rdata_nxt = 32'h00000000;
    case (i_addr)
      `VSS_OFS_CTRL: rdata_nxt = {28'h0000000, ctrl_r};
      `VSS_OFS_SURGE_LIM: rdata_nxt = {24'h000000, surge_lim_r};
      `VSS_OFS_DIP_LIM: rdata_nxt = {24'h000000, dip_lim_r};
      `VSS_OFS_DELAY: rdata_nxt = {26'h0000000, delay_r};
      `VSS_OFS_BLOCK_LIM: rdata_nxt = {24'h000000, block_lim_r};
      `VSS_OFS_STATUS: rdata_nxt = {28'h0000000, status_r};
      `VSS_OFS_MASK: rdata_nxt = {28'h0000000, mask_r};
      `VSS_OFS_LIVE: rdata_nxt = {27'h0000000, live};
      `VSS_OFS_DIP_CNT: rdata_nxt = {16'h0000, dip_cnt_r};
      `VSS_OFS_SURGE_CNT: rdata_nxt = {16'h0000, surge_cnt_r};
      `VSS_OFS_DIP_TOT: rdata_nxt = dip_tot_r;
      `VSS_OFS_SURGE_TOT: rdata_nxt = surge_tot_r;
      `VSS_OFS_LOG_SEL: rdata_nxt = {29'h00000000, sel_r};
      `VSS_OFS_LOG_STAMP: rdata_nxt = sel_rec.stamp;
      `VSS_OFS_LOG_TYPE: rdata_nxt = {29'h00000000, sel_rec.inputs};
      `VSS_OFS_LOG_DUR: rdata_nxt = {16'h0000, sel_rec.duration};
      default: rdata_nxt = lvl_hit ? {24'h000000, lvl_val} : 32'h00000000;
    endcase
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) rdata_r <= 32'h00000000;
    else if (i_rd) rdata_r <= rdata_nxt;
  end

  assign o_rdata = rdata_r;
  assign o_irq = |(status_r & mask_r);

endmodule : voltage_sag_swell_monitor

// ---- verif/vss_front_end.sv ----
// measurement front end model feeding per-input levels
`timescale 1ns/1ns
module vss_front_end import vss_pkg::*; (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_reset,
  // commanded levels and pacing
  input wire logic i_slow,
  input wire volt_t i_level,
  // sample stream
  output logic o_sample_valid,
  output volt_t o_volt
);
  logic [1:0] gap_r = 2'h0;
  logic vld_r = 1'b0;
  volt_t held_r = 24'h646464;
  assign o_sample_valid = vld_r;
  assign o_volt = held_r;
  // a real converter only refreshes its output at a sample point
  always @(posedge i_clk) begin
    if (i_reset) begin
      gap_r <= 2'h0;
      vld_r <= 1'b0;
    end else begin
      gap_r <= (gap_r == 2'h2 || !i_slow) ? 2'h0 : gap_r + 2'h1;
      vld_r <= gap_r == 2'h0;
      if (gap_r == 2'h0) held_r <= i_level;
    end
  end
endmodule : vss_front_end

// ---- verif/vss_monitor_props.sv ----
// port-level assertions for the sag and swell monitor
`timescale 1ns/1ns
`include "vss_params.svh"
module vss_monitor_props import vss_pkg::*; #(
  parameter int STEP_CYCLES = 4
)(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_reset,
  // watched ports
  input wire volt_t i_volt,
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic o_dip_active,
  input wire logic o_surge_active,
  input wire logic o_irq
);
  logic [7:0] dip_r, surge_r, blk_r;
  logic [5:0] dly_r;
  logic [3:0] ctl_r, msk_r;
  logic [15:0] dip_run_r, surge_run_r;
  wire [7:0] wd = i_wdata[7:0];
  wire hi_ok = i_wr && i_wdata[31:8] == 24'h0;
  wire wr_surge = hi_ok && i_addr == `VSS_OFS_SURGE_LIM
    && wd >= `VSS_SURGE_MIN && wd <= `VSS_SURGE_MAX;
  wire wr_dip = hi_ok && i_addr == `VSS_OFS_DIP_LIM
    && wd >= `VSS_DIP_MIN && wd <= `VSS_DIP_MAX;
  wire wr_dly = hi_ok && i_addr == `VSS_OFS_DELAY
    && wd >= `VSS_DELAY_MIN && wd <= `VSS_DELAY_MAX;
  wire wr_blk = hi_ok && i_addr == `VSS_OFS_BLOCK_LIM && wd <= `VSS_BLOCK_MAX;
  wire wr_ctl = i_wr && i_addr == `VSS_OFS_CTRL;
  wire wr_msk = i_wr && i_addr == `VSS_OFS_MASK;
  wire [2:0] below, above, low, mid;
  for (genvar n = 0; n < 3; n++) begin : g_cmp
    assign below[n] = i_volt[n] < dip_r;
    assign above[n] = i_volt[n] > surge_r;
    assign low[n] = i_volt[n] < blk_r;
    assign mid[n] = !low[n] && below[n];
  end
  wire blocked = |low && !(|mid);
  wire dip_q = |below && !blocked;
  wire surge_q = |above;
  // first step may be short, so the hold lies between d-1 steps and d steps plus two cycles
  wire [15:0] lo_w = 16'(dly_r - 6'h1) * 16'(STEP_CYCLES);
  wire [15:0] hi_w = 16'(dly_r) * 16'(STEP_CYCLES) + 16'h2;
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      surge_r <= `VSS_RST_SURGE_LIM;
      dip_r <= `VSS_RST_DIP_LIM;
      dly_r <= `VSS_RST_DELAY;
      blk_r <= `VSS_RST_BLOCK_LIM;
      ctl_r <= `VSS_RST_CTRL;
      msk_r <= 4'h0;
      dip_run_r <= 16'h0;
      surge_run_r <= 16'h0;
    end else begin
      if (wr_surge) surge_r <= wd;
      if (wr_dip) dip_r <= wd;
      if (wr_dly) dly_r <= wd[5:0];
      if (wr_blk) blk_r <= wd;
      if (wr_ctl) ctl_r <= wd[3:0];
      if (wr_msk) msk_r <= wd[3:0];
      dip_run_r <= dip_q ? dip_run_r + 16'h1 : 16'h0;
      surge_run_r <= surge_q ? surge_run_r + 16'h1 : 16'h0;
    end
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);
  sequence s_dip_rise; $rose(o_dip_active); endsequence
  sequence s_surge_rise; $rose(o_surge_active); endsequence
  property p_dip_cause; s_dip_rise |-> $past(dip_q); endproperty
  property p_surge_cause; s_surge_rise |-> $past(surge_q); endproperty
  property p_dip_delay;
    s_dip_rise |-> dip_run_r >= lo_w && dip_run_r <= hi_w;
  endproperty
  property p_surge_delay;
    s_surge_rise |-> surge_run_r >= lo_w && surge_run_r <= hi_w;
  endproperty
  property p_block; s_dip_rise |-> !$past(blocked); endproperty
  property p_dip_end; o_dip_active && !dip_q |=> !o_dip_active; endproperty
  property p_surge_end;
    o_surge_active && !surge_q |=> !o_surge_active;
  endproperty
  property p_irq_start;
    s_dip_rise ##0 (ctl_r[0] && msk_r[0]) |-> ##1 o_irq;
  endproperty
  property p_irq_mask; msk_r == 4'h0 |-> !o_irq; endproperty
  a_dip_cause: assert property (p_dip_cause)
    else $error("sag declared without a sag condition");
  a_surge_cause: assert property (p_surge_cause)
    else $error("swell declared without a swell condition");
  a_dip_delay: assert property (p_dip_delay)
    else $error("sag declared outside the detection delay");
  a_surge_delay: assert property (p_surge_delay)
    else $error("swell declared outside the detection delay");
  a_block: assert property (p_block)
    else $error("sag declared while blocked");
  a_dip_end: assert property (p_dip_end)
    else $error("sag still active after recovery");
  a_surge_end: assert property (p_surge_end)
    else $error("swell still active after recovery");
  a_irq_start: assert property (p_irq_start)
    else $error("no interrupt after enabled sag start");
  a_irq_mask: assert property (p_irq_mask)
    else $error("interrupt raised with all sources masked");
endmodule : vss_monitor_props

bind voltage_sag_swell_monitor vss_monitor_props #(
  .STEP_CYCLES(STEP_CYCLES)
) u_props (
  .i_clk(i_clk),
  .i_reset(i_reset),
  .i_volt(i_volt),
  .i_addr(i_addr),
  .i_wdata(i_wdata),
  .i_wr(i_wr),
  .o_dip_active(o_dip_active),
  .o_surge_active(o_surge_active),
  .o_irq(o_irq)
);

// ---- verif/test_voltage_sag_swell_monitor.sv ----
// self-checking bench for the sag and swell monitor
`timescale 1ns/1ns
`include "vss_params.svh"
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin err_count++; \
  $display("unexpected at %0t: got %h want %h", $time, a, b); end end
module test_voltage_sag_swell_monitor import vss_pkg::*;;
  logic i_clk = 1'b0, i_reset = 1'b1, i_rd = 1'b0, i_wr = 1'b0;
  logic slow = 1'b0, rd_d = 1'b0, sv, o_dip_active, o_surge_active, o_irq;
  logic [7:0] i_addr = 8'h00;
  logic [31:0] i_wdata = 32'h0, i_rtc = 32'h0, o_rdata, seed = 32'h9988;
  logic [31:0] exp_v, exp_q[$];
  volt_t volt, lvl = 24'h646464;
  int err_count = 0, n_compared = 0;
  logic [7:0] rst_a[8] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06,
    8'h0d};
  logic [7:0] rst_v[8] = '{8'h0f, 8'h6e, 8'h5a, 8'h03, 8'h00, 8'h00, 8'h00,
    8'h00};
  // address, write data, value read back
  logic [31:0] tbl[12] = '{32'h01_0013_6e, 32'h01_0097_6e, 32'h01_0096_96,
    32'h02_0009_5a, 32'h02_0079_5a, 32'h02_000a_0a, 32'h03_0001_03,
    32'h03_0033_03, 32'h03_0032_32, 32'h04_0033_00, 32'h04_0032_32,
    32'h04_0132_32};
  vss_front_end fe (.i_clk(i_clk), .i_reset(i_reset), .i_slow(slow),
    .i_level(lvl), .o_sample_valid(sv), .o_volt(volt));
  voltage_sag_swell_monitor #(.STEP_CYCLES(4), .LOG_DEPTH(4)) dut (
    .i_clk(i_clk), .i_reset(i_reset), .i_sample_valid(sv), .i_volt(volt),
    .i_rtc(i_rtc), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .o_rdata(o_rdata), .o_dip_active(o_dip_active),
    .o_surge_active(o_surge_active), .o_irq(o_irq));
  initial begin
    forever #5 i_clk = ~i_clk;
  end
  always @(posedge i_clk) begin
    i_rtc <= i_rtc + 32'h1;
    rd_d <= i_rd;
  end
  // read data stand from the cycle after the strobe until the next read
  always @(negedge i_clk) begin
    if (rd_d && exp_q.size() > 0) begin
      exp_v = exp_q.pop_front();
      `CHK(o_rdata, exp_v)
    end
  end
  task automatic stop_test();
    if (err_count == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : stop_test
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    exp_q.push_back(e);
    @(posedge i_clk);
    i_rd <= 1'b0;
  endtask : rd
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : xs
  // inputs not hit get a random level clear of both default limits
  task automatic set_lvl(input logic [2:0] hit, input logic [7:0] v);
    volt_t nl;
    for (int n = 0; n < 3; n++) begin
      seed = xs(seed);
      nl[n] = hit[n] ? v : 8'h5b + seed[7:0] % 8'h13;
    end
    @(posedge i_clk);
    lvl <= nl;
  endtask : set_lvl
  task automatic wait_act(input logic sw, input logic want);
    int i;
    for (i = 0; i < 200; i++) begin
      @(negedge i_clk);
      if ((sw ? o_surge_active : o_dip_active) === want) break;
    end
    if (i == 200) begin
      err_count++;
      stop_test();
    end
  endtask : wait_act
  task automatic event_run(input logic sw, input logic [2:0] hit,
      input logic [7:0] v);
    set_lvl(hit, v);
    wait_act(sw, 1'b1);
    repeat (3) @(posedge i_clk);
    set_lvl(3'h0, 8'h00);
    wait_act(sw, 1'b0);
    repeat (4) @(posedge i_clk);
  endtask : event_run
  initial begin
    repeat (16) @(posedge i_clk);
    i_reset <= 1'b0;
    foreach (rst_a[k]) rd(rst_a[k], {24'h0, rst_v[k]});
    foreach (tbl[k]) begin
      wr(tbl[k][31:24], {16'h0, tbl[k][23:8]});
      rd(tbl[k][31:24], {24'h0, tbl[k][7:0]});
    end
    wr(`VSS_OFS_SURGE_LIM, 32'h6e);
    wr(`VSS_OFS_DIP_LIM, 32'h5a);
    wr(`VSS_OFS_DELAY, 32'h2);
    wr(`VSS_OFS_BLOCK_LIM, 32'h0);
    wr(`VSS_OFS_MASK, 32'hf);
    set_lvl(3'h0, 8'h00);
    for (int k = 0; k < 5; k++)
      event_run(1'b0, 3'h1 << (k % 3), 8'h28 + 8'(k));
    rd(`VSS_OFS_DIP_CNT, 32'h5);
    rd(`VSS_OFS_STATUS, 32'h3);
    @(negedge i_clk);
    `CHK(o_irq, 1'b1)
    wr(`VSS_OFS_STATUS, 32'h3);
    @(negedge i_clk);
    `CHK(o_irq, 1'b0)
    wr(`VSS_OFS_LOG_SEL, 32'h0);
    rd(`VSS_OFS_LOG_TYPE, 32'h2);
    rd(`VSS_OFS_LOG_LVL + 8'h3, 32'h2c);
    wr(`VSS_OFS_LOG_SEL, 32'h2);
    rd(`VSS_OFS_LOG_TYPE, 32'h2);
    rd(`VSS_OFS_LOG_LVL + 8'h3, 32'h29);
    slow <= 1'b1;
    event_run(1'b1, 3'h6, 8'h78);
    slow <= 1'b0;
    rd(`VSS_OFS_SURGE_CNT, 32'h1);
    rd(`VSS_OFS_STATUS, 32'hc);
    wr(`VSS_OFS_LOG_SEL, 32'h1);
    rd(`VSS_OFS_LOG_TYPE, 32'h6);
    rd(`VSS_OFS_LOG_LVL + 8'h8, 32'h78);
    rd(`VSS_OFS_LOG_LVL + 8'h5, 32'h78);
    // too short to qualify even when the first step is cut short
    set_lvl(3'h1, 8'h32);
    repeat (2) @(posedge i_clk);
    set_lvl(3'h0, 8'h00);
    repeat (12) @(posedge i_clk);
    rd(`VSS_OFS_DIP_CNT, 32'h5);
    wr(`VSS_OFS_STATUS, 32'hf);
    wr(`VSS_OFS_CTRL, 32'h0);
    event_run(1'b0, 3'h1, 8'h32);
    rd(`VSS_OFS_STATUS, 32'h0);
    rd(`VSS_OFS_DIP_CNT, 32'h6);
    @(negedge i_clk);
    `CHK(o_irq, 1'b0)
    wr(`VSS_OFS_CTRL, 32'hf);
    wr(`VSS_OFS_BLOCK_LIM, 32'h1e);
    set_lvl(3'h1, 8'h14);
    repeat (20) @(posedge i_clk);
    @(negedge i_clk);
    `CHK(o_dip_active, 1'b0)
    @(posedge i_clk);
    lvl[1] <= 8'h32;
    wait_act(1'b0, 1'b1);
    set_lvl(3'h0, 8'h00);
    wait_act(1'b0, 1'b0);
    repeat (4) @(posedge i_clk);
    rd(`VSS_OFS_DIP_CNT, 32'h7);
    // seventh sag lands in slot 6 mod 4, with inputs zero and one hit
    wr(`VSS_OFS_LOG_SEL, 32'h4);
    rd(`VSS_OFS_LOG_TYPE, 32'h3);
    rd(`VSS_OFS_LOG_LVL, 32'h14);
    rd(`VSS_OFS_LOG_LVL + 8'h3, 32'h32);
    repeat (4) @(posedge i_clk);
    stop_test();
  end
endmodule : test_voltage_sag_swell_monitor
